/* logic/smsc_monitor.sv */
`timescale 1ns/100ps
`include "smsc_cfg.svh"
// Overview of operation
// - gain from fuses at 0, config at 1
// - bypass bit: registers select sensor directly
// - iteration count sets cycles before full check
// - four slot fields; reset slot3=1, others=5
// - readback returns selected sensor data, read-only
// - ecc enable protects configuration bank
// - ecc error bit injects deliberate bank error
// - sensor codes 0..4, 5..7 reserved
module smsc_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] fuse_gain_i,
  input wire logic [15:0] sensor_data_i,
  input wire logic sensor_data_valid_i,
  output logic [2:0] sensor_sel_o,
  output logic sensor_sel_valid_o,
  output logic [7:0] sensor_gain_o,
  output logic ecc_error_o,
  output logic irq_o
);
  logic [15:0] gain_q;
  logic [15:0] mon2_q;
  logic [15:0] seq_q;
  logic [15:0] lock_q;
  logic [15:0] readback_q;
  logic [`SMSC_IRQ_BITS-1:0] irq_stat_q;
  logic [`SMSC_IRQ_BITS-1:0] irq_mask_q;
  logic [1:0] slot_q;
  logic [1:0] iter_q;
  logic [2:0] all_q;
  logic [2:0] sel_d;
  logic [31:0] rdata_d;
  logic pass_done;
  logic step;
  logic bank_err;
  logic bypass;
  logic bypass_q;
  logic wr;
  logic [9:0] idx;
  smsc_pkg::smsc_state_type state_q;

  assign idx = wb_adr_i[11:2];
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign bypass = seq_q[`SMSC_SEQ_BYPASS];

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0] sel);
    logic [15:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      r[15:8] = dat[15:8];
    end
    return r;
  endfunction

  function automatic logic [2:0] slot_sensor(input logic [15:0] seq,
                                             input logic [1:0] slot);
    return seq[slot*3 +: 3];
  endfunction

  // a single-cycle ack, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gain_q <= `SMSC_RST_GAIN;
      mon2_q <= `SMSC_RST_MON2;
      seq_q <= `SMSC_RST_SEQ;
      lock_q <= `SMSC_RST_LOCK;
      irq_mask_q <= '0;
    end else if (wr) begin
      if (idx == `SMSC_IDX_GAIN) begin
        gain_q <= merge(gain_q, wb_dat_i, wb_sel_i);
      end else if (idx == `SMSC_IDX_MON2) begin
        mon2_q <= merge(mon2_q, wb_dat_i, wb_sel_i);
      end else if (idx == `SMSC_IDX_SEQ) begin
        seq_q <= merge(seq_q, wb_dat_i, wb_sel_i);
      end else if (idx == `SMSC_IDX_LOCK) begin
        lock_q <= merge(lock_q, wb_dat_i, wb_sel_i) & `SMSC_LOCK_WMASK;
      end else if (idx == `SMSC_IDX_IRQ_MASK && wb_sel_i[0]) begin
        irq_mask_q <= wb_dat_i[`SMSC_IRQ_BITS-1:0];
      end
    end
  end

  // sticky events; a new event outranks a write-one clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_q <= '0;
    end else begin
      for (int i = 0; i < `SMSC_IRQ_BITS; i++) begin
        if ((i == `SMSC_IRQ_PASS && pass_done) ||
            (i == `SMSC_IRQ_ECC && bank_err)) begin
          irq_stat_q[i] <= 1'b1;
        end else if (wr && idx == `SMSC_IDX_IRQ_STAT && wb_sel_i[0] &&
                     wb_dat_i[i]) begin
          irq_stat_q[i] <= 1'b0;
        end
      end
    end
  end

  assign irq_o = |(irq_stat_q & irq_mask_q);

  // sequencer: slots 0..3 for iteration count plus one passes, then codes 0..4
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= smsc_pkg::SMSC_ST_SLOTS;
      slot_q <= 2'h0;
      iter_q <= 2'h0;
      all_q <= 3'h0;
      bypass_q <= 1'b0;
    end else begin
      bypass_q <= bypass;
      case (state_q)
        smsc_pkg::SMSC_ST_SLOTS: begin
          if (bypass) begin
            state_q <= smsc_pkg::SMSC_ST_BYPASS;
          end else if (step) begin
            slot_q <= slot_q + 2'h1;
            if (slot_q == `SMSC_SLOT_LAST) begin
              if (iter_q == seq_q[`SMSC_SEQ_ITER_HI:`SMSC_SEQ_ITER_LO]) begin
                iter_q <= 2'h0;
                all_q <= 3'h0;
                state_q <= smsc_pkg::SMSC_ST_ALL;
              end else begin
                iter_q <= iter_q + 2'h1;
              end
            end
          end
        end
        smsc_pkg::SMSC_ST_ALL: begin
          if (bypass) begin
            state_q <= smsc_pkg::SMSC_ST_BYPASS;
          end else if (step) begin
            if (all_q == `SMSC_SENSOR_MAX) begin
              slot_q <= 2'h0;
              state_q <= smsc_pkg::SMSC_ST_SLOTS;
            end else begin
              all_q <= all_q + 3'h1;
            end
          end
        end
        smsc_pkg::SMSC_ST_BYPASS: begin
          if (!bypass) begin
            slot_q <= 2'h0;
            iter_q <= 2'h0;
            state_q <= smsc_pkg::SMSC_ST_SLOTS;
          end
        end
        default: begin
          state_q <= smsc_pkg::SMSC_ST_SLOTS;
        end
      endcase
    end
  end

  assign pass_done = (state_q == smsc_pkg::SMSC_ST_ALL) && step &&
                     (all_q == `SMSC_SENSOR_MAX);

  always_comb begin
    if (state_q == smsc_pkg::SMSC_ST_BYPASS) begin
      sel_d = mon2_q[`SMSC_MON2_SEL_HI:0];
    end else if (state_q == smsc_pkg::SMSC_ST_ALL) begin
      sel_d = all_q;
    end else begin
      sel_d = slot_sensor(seq_q, slot_q);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sensor_sel_o <= 3'h0;
      sensor_sel_valid_o <= 1'b0;
      sensor_gain_o <= `SMSC_FUSE_GAIN_DEF;
    end else begin
      sensor_sel_o <= sel_d;
      // reserved codes 5..7 leave the sensors idle
      sensor_sel_valid_o <= (sel_d <= `SMSC_SENSOR_MAX);
      sensor_gain_o <= seq_q[`SMSC_SEQ_GAIN_SEL] ?
                       gain_q[7:0] : fuse_gain_i;
    end
  end

  // readback holds the latest sample of the sensor being driven
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      readback_q <= `SMSC_RST_ZERO;
    end else if (sensor_data_valid_i && sensor_sel_valid_o) begin
      readback_q <= sensor_data_i;
    end
  end

  smsc_dwell u_dwell (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .restart_i(bypass != bypass_q),
    .step_o(step)
  );

  smsc_ecc_bank u_ecc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .enable_i(lock_q[`SMSC_LOCK_ECC_EN]),
    .inject_i(lock_q[`SMSC_LOCK_ECC_ERR]),
    .bank_i({gain_q, mon2_q, seq_q}),
    .error_o(bank_err)
  );

  assign ecc_error_o = bank_err;

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (idx == `SMSC_IDX_GAIN) begin
      rdata_d[15:0] = gain_q;
    end else if (idx == `SMSC_IDX_MON2) begin
      rdata_d[15:0] = mon2_q;
    end else if (idx == `SMSC_IDX_SEQ) begin
      rdata_d[15:0] = seq_q;
    end else if (idx == `SMSC_IDX_RDBK) begin
      rdata_d[15:0] = readback_q;
    end else if (idx == `SMSC_IDX_LOCK) begin
      rdata_d[15:0] = lock_q;
    end else if (idx == `SMSC_IDX_IRQ_STAT) begin
      rdata_d[`SMSC_IRQ_BITS-1:0] = irq_stat_q;
    end else if (idx == `SMSC_IDX_IRQ_MASK) begin
      rdata_d[`SMSC_IRQ_BITS-1:0] = irq_mask_q;
    end else if (idx == `SMSC_IDX_FUSE_GAIN) begin
      rdata_d[7:0] = fuse_gain_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
      wb_dat_o <= rdata_d;
    end
  end
endmodule

/* pkg/smsc_cfg.svh */
`ifndef SMSC_CFG_SVH
`define SMSC_CFG_SVH

// register indices; byte address is four times the index
`define SMSC_IDX_GAIN       10'h1e7
`define SMSC_IDX_MON2       10'h1e8
`define SMSC_IDX_SEQ        10'h1e9
`define SMSC_IDX_RDBK       10'h1ea
`define SMSC_IDX_LOCK       10'h1ee
`define SMSC_IDX_IRQ_STAT   10'h1f0
`define SMSC_IDX_IRQ_MASK   10'h1f1
`define SMSC_IDX_FUSE_GAIN  10'h1f2

`define SMSC_RST_GAIN       16'h0012
`define SMSC_RST_MON2       16'h0920
`define SMSC_RST_SEQ        16'h036d
`define SMSC_RST_LOCK       16'h0035
`define SMSC_RST_ZERO       16'h0000
`define SMSC_FUSE_GAIN_DEF  8'h12

`define SMSC_SEQ_GAIN_SEL   15
`define SMSC_SEQ_BYPASS     14
`define SMSC_SEQ_ITER_HI    13
`define SMSC_SEQ_ITER_LO    12
`define SMSC_MON2_SEL_HI    2
`define SMSC_LOCK_ECC_EN    8
`define SMSC_LOCK_ECC_ERR   7
`define SMSC_LOCK_WMASK     16'hffff

`define SMSC_SENSOR_MAX     3'h4
`define SMSC_SLOT_LAST      2'h3
`define SMSC_DWELL_CYC      8'hff

// irq status bits
`define SMSC_IRQ_PASS       0
`define SMSC_IRQ_ECC        1
`define SMSC_IRQ_BITS       2

`endif

/* pkg/smsc_pkg.sv */
package smsc_pkg;
  typedef enum logic [2:0] {
    SMSC_ANALOG_2V5_SUPPLY,
    SMSC_ANALOG_1V8_SUPPLY,
    SMSC_CORE_1V1_SUPPLY,
    SMSC_IO_SUPPLY,
    SMSC_TEMPERATURE
  } smsc_sensor_type;

  typedef enum logic [1:0] {
    SMSC_ST_SLOTS,
    SMSC_ST_ALL,
    SMSC_ST_BYPASS
  } smsc_state_type;
endpackage

/* logic/smsc_dwell.sv */
`timescale 1ns/100ps
`include "smsc_cfg.svh"
// one-cycle step enable after each sensor dwell period
module smsc_dwell (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic restart_i,
  output logic step_o
);
  logic [7:0] cnt_q;

  always_ff @(posedge clk_i) begin
    if (rst_i || restart_i || step_o) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  assign step_o = (cnt_q == `SMSC_DWELL_CYC);
endmodule

/* logic/smsc_ecc_bank.sv */
`timescale 1ns/100ps
`include "smsc_cfg.svh"
// six-bit interleaved parity guard over the configuration words
module smsc_ecc_bank (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic inject_i,
  input wire logic [47:0] bank_i,
  output logic error_o
);
  logic [5:0] sum_q;
  logic armed_q;

  function automatic logic [5:0] fold(input logic [47:0] w);
    logic [5:0] s;
    s = 6'h00;
    for (int i = 0; i < 48; i++) begin
      s[i % 6] = s[i % 6] ^ w[i];
    end
    return s;
  endfunction

  // checksum follows software writes only while disabled or recaptured
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sum_q <= 6'h00;
      armed_q <= 1'b0;
    end else begin
      armed_q <= enable_i;
      if (!enable_i || !armed_q) begin
        sum_q <= fold(bank_i);
      end
    end
  end

  // injected flip on bit 0 makes detection fire on purpose
  assign error_o = enable_i && armed_q &&
    ((fold(bank_i) ^ {5'h00, inject_i}) != sum_q);
endmodule

/* test/smsc_monitor_properties.sv */
`timescale 1ns/100ps
module smsc_monitor_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [2:0] sensor_sel_o,
  input wire logic sensor_sel_valid_o,
  input wire logic [7:0] sensor_gain_o,
  input wire logic ecc_error_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_i); endclocking
  chk_ack_after_req: assert property (disable iff (rst_i)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  chk_ack_one_pulse: assert property (disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  chk_ack_needs_req: assert property (disable iff (rst_i)
    $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
  chk_read_data_hold: assert property (disable iff (rst_i)
    wb_ack_o && !wb_we_i |=> $stable(wb_dat_o)) else $error("data moved");
  chk_upper_lanes_zero: assert property (disable iff (rst_i)
    wb_ack_o |-> wb_dat_o[31:16] == 16'h0000) else $error("upper bits");
  chk_sel_code_legal: assert property (disable iff (rst_i)
    sensor_sel_valid_o |-> sensor_sel_o <= 3'h4) else $error("bad code");
  chk_reset_bus_quiet: assert property (
    rst_i |=> !wb_ack_o && wb_dat_o == 32'h0000_0000) else $error("bus rst");
  chk_reset_out_defaults: assert property (
    rst_i |=> sensor_gain_o == 8'h12 && !irq_o && !ecc_error_o
      && !sensor_sel_valid_o) else $error("outputs rst");
  cover property (wb_ack_o && wb_we_i);
  cover property ($rose(irq_o));
  cover property ($rose(ecc_error_o));
endmodule

/* test/smsc_monitor_tb.sv */
`timescale 1ns/100ps
module smsc_monitor_tb;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [3:0] wb_sel_i = 4'h3;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o;
  logic wb_ack_o, sensor_sel_valid_o, ecc_error_o, irq_o, svld = 0;
  logic [7:0] fuse_gain_i = 8'h5a, sensor_gain_o;
  logic [15:0] sdat = 16'h0000, v, last = 16'h0000;
  logic [2:0] sensor_sel_o, prev_sel = 3'h0;
  logic [15:0] exq[$];
  logic [2:0] seq[$];
  logic [2:0] exps[11] = '{2, 1, 0, 3, 2, 1, 0, 1, 2, 3, 4};
  int bad_count = 0, compares = 0, cyc = 0, i, j;
  always #5 clk_i = ~clk_i;
  smsc_monitor i_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .fuse_gain_i,
    .sensor_data_i(sdat), .sensor_data_valid_i(svld), .sensor_sel_o,
    .sensor_sel_valid_o, .sensor_gain_o, .ecc_error_o, .irq_o);
  task automatic results;
    $display("compares=%0d mismatches=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic [9:0] idx, input logic we,
                    input logic [15:0] d);
    wb_adr_i <= {idx, 2'b00};
    wb_we_i <= we;
    wb_dat_i <= {16'h0000, d};
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [9:0] idx, input logic [15:0] e);
    exq.push_back(e);
    wb(idx, 0, 16'h0000);
  endtask
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exq.size() > 0)
      cmp(wb_dat_o[15:0], exq.pop_front());
    // plain history compare keeps this process free of sampled functions
    if (sensor_sel_o !== prev_sel) seq.push_back(sensor_sel_o);
    prev_sel = sensor_sel_o;
    cyc++;
    // covers a full pass twice plus register traffic
    if (cyc == 20000) begin
      bad_count++;
      results();
    end
  end
  initial begin
    void'($urandom(55));
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    rd(10'h1e9, 16'h036d);
    rd(10'h1ea, 16'h0000);
    rd(10'h1ee, 16'h0035);
    v = 16'($urandom);
    wb(10'h100, 1, v);
    rd(10'h100, 16'h0000);
    wb(10'h1ea, 1, v);
    rd(10'h1ea, 16'h0000);
    wb(10'h1e9, 1, v);
    rd(10'h1e9, v);
    $display("test registers done");
    fuse_gain_i <= 8'($urandom);
    wb(10'h1e9, 1, 16'h036d);
    cmp({8'h00, sensor_gain_o}, {8'h00, fuse_gain_i});
    rd(10'h1f2, {8'h00, fuse_gain_i});
    wb(10'h1e7, 1, 16'h00c3);
    wb(10'h1e9, 1, 16'h836d);
    cmp({8'h00, sensor_gain_o}, 16'h00c3);
    $display("test gain done");
    wb(10'h1e9, 1, 16'h436d);
    for (i = 0; i < 8; i++) begin
      wb(10'h1e8, 1, 16'h0920 | 16'(i));
      repeat (2) @(posedge clk_i);
      cmp(16'(sensor_sel_o), 16'(i));
      cmp(16'(sensor_sel_valid_o), 16'(i < 5));
      v = 16'($urandom);
      if (i < 5) last = v;
      sdat <= v;
      svld <= 1;
      @(posedge clk_i);
      svld <= 0;
      rd(10'h1ea, last);
    end
    $display("test bypass done");
    wb(10'h1f1, 1, 16'h0001);
    wb(10'h1e9, 1, 16'h1053);
    while (irq_o !== 1'b1) @(posedge clk_i);
    wb(10'h1f0, 1, 16'h0001);
    cmp(16'(irq_o), 16'h0000);
    seq.delete();
    while (irq_o !== 1'b1) @(posedge clk_i);
    repeat (2) @(posedge clk_i);
    i = seq.size() - 1;
    while (i > 0 && seq[i] != 3'h4) i--;
    for (j = 0; j < 11; j++) cmp(16'(seq[i - 10 + j]), 16'(exps[j]));
    wb(10'h1f1, 1, 16'h0000);
    cmp(16'(irq_o), 16'h0000);
    wb(10'h1f1, 1, 16'h0002);
    wb(10'h1f0, 1, 16'h0003);
    $display("test sequence done");
    wb(10'h1ee, 1, 16'h00b5);
    cmp(16'(ecc_error_o), 16'h0000);
    wb(10'h1ee, 1, 16'h0135);
    rd(10'h1ee, 16'h0135);
    cmp(16'(ecc_error_o), 16'h0000);
    wb(10'h1ee, 1, 16'h01b5);
    cmp(16'(ecc_error_o), 16'h0001);
    cmp(16'(irq_o), 16'h0001);
    wb(10'h1ee, 1, 16'h0035);
    wb(10'h1f0, 1, 16'h0003);
    cmp(16'(irq_o), 16'h0000);
    $display("test ecc done");
    results();
  end
endmodule
bind smsc_monitor smsc_monitor_properties i_chk (.clk_i, .rst_i,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_dat_o, .wb_ack_o, .sensor_sel_o,
  .sensor_sel_valid_o, .sensor_gain_o, .ecc_error_o, .irq_o);
